// ### core/pcis_core.sv
// management-port slave with the interrupt control/status register of the phy
// What this block does
// R1: bit 10 is read-write link-down interrupt enable, reset zero.
// R2: bit 9 is read-write remote-fault interrupt enable, reset zero.
// R3: bit 8 is read-write link-up interrupt enable, reset zero.
// R4: bit 7 latches jabber events, read-only, cleared by read, reset zero.
// R5: bit 6 latches receive errors, read-only, cleared by read, reset zero.
// R6: bit 5 latches received pages, read-only, cleared by read, reset zero.
// R7: bit 4 latches parallel detect faults, read-only, cleared by read, reset zero.
// R8: bit 3 latches link partner acknowledge, read-only, cleared by read.
// R9: bit 2 latches link down events, read-only, cleared by read, reset zero.
// R10: bit 1 latches remote faults, read-only, cleared by read, reset zero.
// R11: bit 0 latches link up events, read-only, cleared by read, reset zero.
// R12: bit 14 is read-write receive-error interrupt enable, reset zero.
// R13: bit 13 is read-write page-received interrupt enable, reset zero.
// R14: bit 12 is read-write parallel-detect-fault interrupt enable, reset zero.
// R15: bit 11 is read-write link-partner-acknowledge interrupt enable, reset zero.
// R16: interrupt high while any flag and its enable are set; reads clear flags.
`timescale 1ns/1ps
module pcis_core #(
    parameter logic [4:0] PHY_ADDR = pcis_pkg::PHY_ADDR_DEFAULT,
    parameter logic [5:0] PRE_LEN  = pcis_pkg::PREAMBLE_LEN
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire logic                mdc,
    input  wire logic                mdio_in,
    output logic                     mdio_out,
    output logic                     mdio_oe,
    input  wire pcis_pkg::pcis_event_s events,
    output logic                     irq
);
    // the hunt counter saturates at PRE_LEN, so zero or more than 32 cannot be served
    if (PRE_LEN == 6'h00 || PRE_LEN > pcis_pkg::PREAMBLE_LEN) begin : g_bad_pre_len
        $error("preamble length must be 1 to 32");
    end

    pcis_pkg::pcis_state_e state;
    pcis_pkg::pcis_state_e next_state;
    logic [3:0]            bit_cnt;
    logic [3:0]            next_cnt;
    logic [5:0]            pre_cnt;
    logic [5:0]            next_pre;
    logic                  mdc_prev;
    logic [15:0]           shreg;
    logic [15:0]           tx;
    logic                  is_read;
    logic                  hit;
    pcis_pkg::pcis_event_s flags;
    pcis_pkg::pcis_event_s en;
    pcis_pkg::pcis_event_s next_flags;

    // mdc is taken as synchronous; bits are sampled on its rising edge
    wire        mdc_rise   = ce & mdc & ~mdc_prev;
    wire [15:0] frame_word = {shreg[14:0], mdio_in};
    wire [1:0]  opcode     = {shreg[0], mdio_in};
    wire        addr_end   = mdc_rise && state == pcis_pkg::PCIS_ADDR
                             && bit_cnt == pcis_pkg::ADDR_LAST;
    wire        frame_hit  = frame_word[9:0] == {PHY_ADDR, pcis_pkg::REG_INT_CTRL_STATUS};
    wire        ta_first   = mdc_rise && state == pcis_pkg::PCIS_TA
                             && bit_cnt == 4'h0 && is_read && hit;
    wire        rd_capture = mdc_rise && state == pcis_pkg::PCIS_TA
                             && bit_cnt == pcis_pkg::TA_LAST && is_read && hit;
    wire        data_end   = mdc_rise && state == pcis_pkg::PCIS_DATA
                             && bit_cnt == pcis_pkg::DATA_LAST;
    wire        wr_commit  = data_end && !is_read && hit;
    wire [15:0] reg_value  = {en, flags};
    // only bits that were read as one are cleared; a new event still sets its bit
    wire [7:0]  clr_mask   = rd_capture ? flags : pcis_pkg::FLAG_RESET;

    assign next_flags = pcis_pkg::pcis_event_s'((flags & ~clr_mask) | events); // R16

    always_comb begin
        next_state = state;
        next_cnt   = bit_cnt;
        next_pre   = pre_cnt;
        if (mdc_rise) begin
            case (state)
                pcis_pkg::PCIS_PRE: begin
                    if (mdio_in) begin
                        next_pre = (pre_cnt == PRE_LEN) ? pre_cnt : pre_cnt + 6'h01;
                    end else begin
                        if (pre_cnt == PRE_LEN) begin
                            next_state = pcis_pkg::PCIS_ST;
                        end
                        next_pre = 6'h00;
                    end
                end
                pcis_pkg::PCIS_ST: begin
                    next_state = mdio_in ? pcis_pkg::PCIS_OP : pcis_pkg::PCIS_PRE;
                    next_cnt   = 4'h0;
                end
                pcis_pkg::PCIS_OP: begin
                    if (bit_cnt != pcis_pkg::OP_LAST) begin
                        next_cnt = bit_cnt + 4'h1;
                    end else begin
                        next_cnt = 4'h0;
                        // any other opcode drops the frame silently
                        if (opcode == pcis_pkg::OP_READ || opcode == pcis_pkg::OP_WRITE) begin
                            next_state = pcis_pkg::PCIS_ADDR;
                        end else begin
                            next_state = pcis_pkg::PCIS_PRE;
                        end
                    end
                end
                pcis_pkg::PCIS_ADDR: begin
                    if (bit_cnt == pcis_pkg::ADDR_LAST) begin
                        next_state = pcis_pkg::PCIS_TA;
                        next_cnt   = 4'h0;
                    end else begin
                        next_cnt = bit_cnt + 4'h1;
                    end
                end
                pcis_pkg::PCIS_TA: begin
                    if (bit_cnt == pcis_pkg::TA_LAST) begin
                        next_state = pcis_pkg::PCIS_DATA;
                        next_cnt   = 4'h0;
                    end else begin
                        next_cnt = bit_cnt + 4'h1;
                    end
                end
                pcis_pkg::PCIS_DATA: begin
                    if (bit_cnt == pcis_pkg::DATA_LAST) begin
                        // a fresh preamble is needed before the next frame
                        next_state = pcis_pkg::PCIS_PRE;
                        next_cnt   = 4'h0;
                    end else begin
                        next_cnt = bit_cnt + 4'h1;
                    end
                end
                default: begin
                    next_state = pcis_pkg::PCIS_PRE;
                    next_cnt   = 4'h0;
                    next_pre   = 6'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= pcis_pkg::PCIS_PRE;
            bit_cnt  <= 4'h0;
            pre_cnt  <= 6'h00;
            mdc_prev <= 1'b0;
        end else if (ce) begin
            state    <= next_state;
            bit_cnt  <= next_cnt;
            pre_cnt  <= next_pre;
            mdc_prev <= mdc;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg   <= 16'h0000;
            is_read <= 1'b0;
            hit     <= 1'b0;
        end else if (mdc_rise) begin
            shreg <= frame_word;
            if (state == pcis_pkg::PCIS_OP && bit_cnt == pcis_pkg::OP_LAST) begin
                is_read <= opcode == pcis_pkg::OP_READ;
            end
            if (addr_end) begin
                hit <= frame_hit;
            end
        end
    end

    // read data: turnaround zero, then sixteen bits msb first, each for one mdc period
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b0;
            tx       <= 16'h0000;
        end else if (ta_first) begin
            mdio_oe  <= 1'b1;
            mdio_out <= 1'b0;
        end else if (rd_capture) begin
            mdio_out <= reg_value[15];
            tx       <= {reg_value[14:0], 1'b0};
        end else if (data_end) begin
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b0;
        end else if (mdc_rise && state == pcis_pkg::PCIS_DATA && mdio_oe) begin
            mdio_out <= tx[15];
            tx       <= {tx[14:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en <= pcis_pkg::pcis_event_s'(pcis_pkg::EN_RESET);
        end else if (wr_commit) begin // R2 R3 R12 R13 R14 R15
            en <= pcis_pkg::pcis_event_s'(frame_word[pcis_pkg::EN_HI:pcis_pkg::EN_LO]); // R1
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= pcis_pkg::pcis_event_s'(pcis_pkg::FLAG_RESET);
            irq   <= 1'b0;
        end else if (ce) begin
            flags <= next_flags; // R4 R5 R6 R7 R8 R9 R10 R11
            irq   <= |(flags & en); // R16
        end
    end

    sequence s_read_capture;
        rd_capture;
    endsequence

    sequence s_enabled_event;
        ce && (flags.link_down && en.link_down);
    endsequence

    // read answer: the line is pulled low for the second turnaround bit
    sequence s_turnaround;
        ta_first;
    endsequence

    a_ld_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
        wr_commit |=> en.link_down == $past(frame_word[10]))
        else $error("link-down enable not written");
    a_rf_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
        wr_commit |=> en.remote_fault == $past(frame_word[9]))
        else $error("remote-fault enable not written");
    a_lu_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
        wr_commit |=> en.link_up == $past(frame_word[8]))
        else $error("link-up enable not written");
    a_jabber_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
        ce && events.jabber |=> flags.jabber)
        else $error("jabber flag not set");
    a_rxerr_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        ce && events.rx_error |=> flags.rx_error)
        else $error("receive error flag not set");
    a_page_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
        ce && events.page_rx |=> flags.page_rx)
        else $error("page flag not set");
    a_pdf_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        ce && events.par_det_fault |=> flags.par_det_fault)
        else $error("parallel detect flag not set");
    a_lpack_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        ce && events.lp_ack |=> flags.lp_ack)
        else $error("partner acknowledge flag not set");
    a_ld_flag_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
        flags.link_down && !rd_capture |=> flags.link_down)
        else $error("link-down flag lost without read");
    a_rf_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
        ce && events.remote_fault |=> flags.remote_fault)
        else $error("remote fault flag not set");
    a_read_clears_flag: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
        s_read_capture ##0 (flags.link_up && !events.link_up) |=> !flags.link_up)
        else $error("link-up flag not cleared by read");
    a_enable_stable: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
        !wr_commit |=> $stable(en))
        else $error("enables changed without a write");
    a_page_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
        wr_commit |=> en.page_rx == $past(frame_word[13]))
        else $error("page enable not written");
    a_pdf_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
        wr_commit |=> en.par_det_fault == $past(frame_word[12]))
        else $error("parallel detect enable not written");
    a_lpack_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
        wr_commit |=> en.lp_ack == $past(frame_word[11]))
        else $error("partner acknowledge enable not written");
    a_irq_follows_cause: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        s_enabled_event |=> irq)
        else $error("interrupt missing for enabled flag");
    a_irq_needs_cause: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        ce && (flags & en) == 8'h00 |=> !irq)
        else $error("interrupt without enabled flag");
    a_rxerr_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
        wr_commit |=> en.rx_error == $past(frame_word[14]))
        else $error("receive error enable not written");
    a_ld_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
        ce && events.link_down |=> flags.link_down)
        else $error("link-down flag not set");
    a_lu_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
        ce && events.link_up |=> flags.link_up)
        else $error("link-up flag not set");
    a_jabber_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
        s_read_capture ##0 (flags.jabber && !events.jabber) |=> !flags.jabber)
        else $error("jabber flag not cleared by read");
    a_rxerr_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        s_read_capture ##0 (flags.rx_error && !events.rx_error) |=> !flags.rx_error)
        else $error("receive error flag not cleared by read");
    a_page_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
        s_read_capture ##0 (flags.page_rx && !events.page_rx) |=> !flags.page_rx)
        else $error("page flag not cleared by read");
    a_pdf_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        s_read_capture ##0 (flags.par_det_fault && !events.par_det_fault)
        |=> !flags.par_det_fault)
        else $error("parallel detect flag not cleared by read");
    a_lpack_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        s_read_capture ##0 (flags.lp_ack && !events.lp_ack) |=> !flags.lp_ack)
        else $error("partner acknowledge flag not cleared by read");
    a_rf_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
        s_read_capture ##0 (flags.remote_fault && !events.remote_fault)
        |=> !flags.remote_fault)
        else $error("remote fault flag not cleared by read");
    a_read_turnaround: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        s_turnaround |=> mdio_oe && !mdio_out)
        else $error("turnaround not driven low");
    a_read_msb_first: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        s_read_capture |=> mdio_oe && mdio_out == $past(reg_value[15]))
        else $error("first read bit wrong");
endmodule

// ### core/pcis_pkg.sv
// constants, types and register layout of the phy interrupt control/status block
package pcis_pkg;
    localparam logic [4:0] REG_INT_CTRL_STATUS = 5'h1B;
    localparam logic [4:0] PHY_ADDR_DEFAULT    = 5'h00;  // arbitrary strap value
    localparam logic [5:0] PREAMBLE_LEN        = 6'h20;
    localparam logic [1:0] OP_READ             = 2'h2;
    localparam logic [1:0] OP_WRITE            = 2'h1;
    localparam logic [3:0] ADDR_LAST           = 4'h9;   // phy address + register address
    localparam logic [3:0] DATA_LAST           = 4'hF;
    localparam logic [3:0] TA_LAST             = 4'h1;
    localparam logic [3:0] OP_LAST             = 4'h1;
    localparam int         EN_LO               = 8;
    localparam int         EN_HI               = 15;
    localparam logic [7:0] EN_RESET            = 8'h00;
    localparam logic [7:0] FLAG_RESET          = 8'h00;

    // one bit per link event; the same order serves flags (bits 7:0) and enables (15:8)
    typedef struct packed {
        logic jabber;
        logic rx_error;
        logic page_rx;
        logic par_det_fault;
        logic lp_ack;
        logic link_down;
        logic remote_fault;
        logic link_up;
    } pcis_event_s;

    typedef enum logic [2:0] {
        PCIS_PRE  = 3'b000,
        PCIS_ST   = 3'b001,
        PCIS_OP   = 3'b010,
        PCIS_ADDR = 3'b011,
        PCIS_TA   = 3'b100,
        PCIS_DATA = 3'b101
    } pcis_state_e;
endpackage

// ### verification/pcis_mgmt_model.sv
// management station model: drives mdc and the shared data line, samples read data
`timescale 1ns/1ps
module pcis_mgmt_model #(
    parameter int PRE = 8
) (
    input  wire logic core_clk,
    input  wire logic mdio_out,
    input  wire logic mdio_oe,
    output logic      mdc,
    output logic      mdio_in
);
    logic drv_en;
    logic drv_val;

    // pull-up on the shared line: released by both sides it reads one
    assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);

    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_val = 1'b1;
    end

    // two cycles low, two high; sample just before the rise, as a station does
    task automatic send_bit(input logic en, input logic val, output logic smp);
        @(negedge core_clk);
        mdc = 1'b0;
        drv_en = en;
        drv_val = val;
        repeat (2) @(negedge core_clk);
        smp = mdio_in;
        mdc = 1'b1;
        @(negedge core_clk);
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [13:0] hdr;
        logic        is_rd;
        logic        s;
        hdr = {2'b01, op, phy, rg};
        is_rd = (op == pcis_pkg::OP_READ);
        for (int i = 0; i < PRE; i++) send_bit(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) send_bit(1'b1, hdr[i], s);
        send_bit(!is_rd, 1'b1, s);
        send_bit(!is_rd, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            send_bit(!is_rd, wdata[i], s);
            rdata[i] = s;
        end
        // clock stands still between frames
        @(negedge core_clk);
        mdc = 1'b0;
        drv_en = 1'b0;
    endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench for the interrupt control/status block
`timescale 1ns/1ps
module tb_top;
    localparam logic [4:0] REG = pcis_pkg::REG_INT_CTRL_STATUS;
    logic                  core_clk;
    logic                  rst_n;
    logic                  ce;
    logic                  mdc;
    logic                  mdio_in;
    logic                  mdio_out;
    logic                  mdio_oe;
    logic                  irq;
    pcis_pkg::pcis_event_s events;
    int                    num_errors;
    int                    checks;
    logic [15:0]           rd;

    pcis_core #(.PHY_ADDR(pcis_pkg::PHY_ADDR_DEFAULT), .PRE_LEN(6'h08)) pcis_core_i (
        .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .events(events), .irq(irq));
    pcis_mgmt_model #(.PRE(8)) pcis_mgmt_model_i (
        .core_clk(core_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
        .mdio_in(mdio_in));

    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic rd_reg(input logic [4:0] rg, output logic [15:0] v);
        pcis_mgmt_model_i.frame(pcis_pkg::OP_READ, pcis_pkg::PHY_ADDR_DEFAULT, rg, 16'h0000, v);
    endtask

    task automatic wr_reg(input logic [4:0] rg, input logic [15:0] v);
        logic [15:0] dummy;
        pcis_mgmt_model_i.frame(pcis_pkg::OP_WRITE, pcis_pkg::PHY_ADDR_DEFAULT, rg, v, dummy);
    endtask

    task automatic pulse(input logic [7:0] ev);
        @(negedge core_clk);
        events = ev;
        @(negedge core_clk);
        events = 8'h00;
    endtask

    // irq is registered, so a few cycles of slack are allowed
    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq !== exp && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        chk({15'h0000, irq}, {15'h0000, exp});
        if (irq !== exp) stop_test();
    endtask

    task automatic t_reset_values();
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(REG, rd);
        chk(rd, 16'h0000);
    endtask

    // one enable at a time; ones written to the flag half must not stick
    task automatic t_enables();
        for (int k = 0; k < 8; k++) begin
            wr_reg(REG, (16'h0100 << k) | 16'h00FF);
            rd_reg(REG, rd);
            chk(rd, 16'h0100 << k);
        end
    endtask

    task automatic t_flags();
        logic [15:0] f;
        for (int k = 0; k < 8; k++) begin
            f = 16'h0001 << k;
            wr_reg(REG, ~(f << 8) & 16'hFF00);
            pulse(f[7:0]);
            repeat (4) @(negedge core_clk);
            chk({15'h0000, irq}, 16'h0000);
            wr_reg(REG, f << 8);
            wait_irq(1'b1);
            rd_reg(REG, rd);
            chk(rd, (f << 8) | f);
            wait_irq(1'b0);
            rd_reg(REG, rd);
            chk(rd, f << 8);
        end
    endtask

    // foreign addresses and a bad opcode: no drive, no write, no flag clear
    task automatic t_refused();
        pulse(8'h01);
        rd_reg(5'h1A, rd);
        chk(rd, 16'hFFFF);
        pcis_mgmt_model_i.frame(pcis_pkg::OP_READ, pcis_pkg::PHY_ADDR_DEFAULT ^ 5'h01, REG,
                                16'h0000, rd);
        chk(rd, 16'hFFFF);
        pcis_mgmt_model_i.frame(2'h3, pcis_pkg::PHY_ADDR_DEFAULT, REG, 16'h5500, rd);
        wr_reg(5'h1A, 16'hFF00);
        rd_reg(REG, rd);
        chk(rd, 16'h8001);
    endtask

    // ce low freezes the flags: an event seen then is lost
    task automatic t_ce_freeze();
        wr_reg(REG, 16'h0100);
        @(negedge core_clk);
        ce = 1'b0;
        pulse(8'h01);
        repeat (4) @(negedge core_clk);
        ce = 1'b1;
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(REG, rd);
        chk(rd, 16'h0100);
        pulse(8'h01);
        wait_irq(1'b1);
        rd_reg(REG, rd);
        chk(rd, 16'h0101);
    endtask

    task automatic t_mid_reset();
        wr_reg(REG, 16'hFF00);
        pulse(8'hFF);
        wait_irq(1'b1);
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(REG, rd);
        chk(rd, 16'h0000);
    endtask

    initial begin
        num_errors = 0;
        checks = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        events = 8'h00;
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset_values();
        t_enables();
        t_flags();
        t_refused();
        t_ce_freeze();
        t_mid_reset();
        stop_test();
    end
endmodule
